// file: hdl/link_status_word_encoder.sv
// Link status word encoder: builds bits 0 to 13 of the link status word and
// answers get-link-status requests with it; small register port for control.
// Assumes PHY status and request inputs are synchronous to CLOCK.
//
// Summary of operation
// - Bit 0 shows link up, idle counts up.
// - Answer every request without checksum or identifier error.
// - Speed zero: negotiation incomplete, SerDes, no common.
// - Codes 0x1 to 0x3 and 0x5 to 0x7 for slow copper.
// - Ten gigabit reports code 0x8.
// - Optional codes 0x9 to 0xE, reserved legacy.
// - Code 0xF defers to extended speed field.
// - Forced setting reported when SerDes clear and link up.
// - Unlisted speed reports nearest code.
// - Bit 5 shows negotiation enabled and supported.
// - Bit 6 shows negotiation completed.
// - Complete flag implemented with enabled flag.
// - Bit 7 only for parallel detection link.
// - Bits 9, 10 gigabit partner abilities, gated.
// - Bit 11 four pair partner ability, gated.
// - Bits 12, 13 fast partner abilities, gated.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "lsw_params.svh"

module link_status_word_encoder (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire lsw_pkg::phy_status_type PHY_STATUS,
   input wire logic REQ,
   input wire logic REQ_CHECKSUM_BAD,
   input wire logic REQ_ID_BAD,
   input wire logic [`LSW_ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic RESP_VALID,
   output logic [`LSW_WORD_W-1:0] RESP_WORD,
   output logic [31:0] RDATA
);

   lsw_pkg::state_type state_reg;
   lsw_pkg::state_type state_next;
   logic an_flag;
   logic an_complete;
   logic abil_valid;
   logic req_ok;
   logic [3:0] speed_code;
   logic [`LSW_WORD_W-1:0] live_word;

   // Maps the resolved medium to a speed code. Legacy readers treat 0x9 to 0xF
   // as reserved, so those media fall back to the nearest listed code, or to zero for 0xF.
   function automatic logic [3:0] media_code(input lsw_pkg::media_type m,
                                             input logic legacy,
                                             input logic ext_ok);
      logic [3:0] c;
      c = `LSW_SPD_NONE;
      unique case (m)
         lsw_pkg::MEDIA_NONE: c = `LSW_SPD_NONE;
         lsw_pkg::MEDIA_10H: c = `LSW_SPD_10H;
         lsw_pkg::MEDIA_10F: c = `LSW_SPD_10F;
         lsw_pkg::MEDIA_100H: c = `LSW_SPD_100H;
         lsw_pkg::MEDIA_100F: c = `LSW_SPD_100F;
         lsw_pkg::MEDIA_1000H: c = `LSW_SPD_1000H;
         lsw_pkg::MEDIA_1000F: c = `LSW_SPD_1000F;
         lsw_pkg::MEDIA_10G: c = `LSW_SPD_10G;
         lsw_pkg::MEDIA_20G: c = legacy ? `LSW_SPD_10G : `LSW_SPD_20G;
         lsw_pkg::MEDIA_25G: c = legacy ? `LSW_SPD_10G : `LSW_SPD_25G;
         lsw_pkg::MEDIA_40G: c = legacy ? `LSW_SPD_10G : `LSW_SPD_40G;
         lsw_pkg::MEDIA_50G: c = legacy ? `LSW_SPD_10G : `LSW_SPD_50G;
         lsw_pkg::MEDIA_100G: c = legacy ? `LSW_SPD_10G : `LSW_SPD_100G;
         lsw_pkg::MEDIA_2G5: c = legacy ? `LSW_SPD_1000F : `LSW_SPD_2G5;
         // Extended field only when allowed and the reader is not legacy.
         lsw_pkg::MEDIA_EXT: c = (ext_ok && !legacy) ? `LSW_SPD_EXT : `LSW_SPD_NONE;
         default: c = `LSW_SPD_NONE;
      endcase
      return c;
   endfunction

   // Negotiation flags; completion is only reported while negotiation is on.
   assign an_flag = state_reg.ctrl.an_supported & state_reg.ctrl.an_enable;
   assign an_complete = an_flag & PHY_STATUS.an_done;
   assign abil_valid = ~PHY_STATUS.serdes & an_flag & an_complete;
   assign req_ok = REQ & ~REQ_CHECKSUM_BAD & ~REQ_ID_BAD;

   // Speed field: zero on SerDes, pending negotiation or no common ability.
   // With negotiation off the forced setting is reported while the link is up, zero while it is down.
   always_comb begin
      if (PHY_STATUS.serdes || (an_flag && !an_complete)) begin
         speed_code = `LSW_SPD_NONE;
      end else if (an_flag && !PHY_STATUS.highest_common_ability) begin
         speed_code = `LSW_SPD_NONE;
      end else if (!an_flag && !PHY_STATUS.link_up) begin
         speed_code = `LSW_SPD_NONE;
      end else begin
         speed_code = media_code(PHY_STATUS.media, state_reg.ctrl.legacy,
                                 state_reg.ctrl.ext_ok);
      end
   end

   // Assemble the word from the flags above.
   always_comb begin
      live_word = '0;
      live_word[`LSW_LINK_BIT] = PHY_STATUS.link_up | PHY_STATUS.low_power_idle;
      live_word[`LSW_SPEED_HI:`LSW_SPEED_LO] = speed_code;
      live_word[`LSW_AN_EN_BIT] = an_flag;
      live_word[`LSW_AN_DONE_BIT] = an_complete;
      live_word[`LSW_PDET_BIT] = an_complete & PHY_STATUS.parallel_det;
      live_word[`LSW_RSVD_BIT] = 1'b0;
      live_word[`LSW_GIG_FULL_BIT] = abil_valid & PHY_STATUS.partner_gig_copper_full;
      live_word[`LSW_GIG_HALF_BIT] = abil_valid & PHY_STATUS.partner_gig_copper_half;
      live_word[`LSW_FAST_T4_BIT] = abil_valid & PHY_STATUS.partner_fast_four_pair;
      live_word[`LSW_FAST_FULL_BIT] = abil_valid & PHY_STATUS.partner_fast_tx_full;
      live_word[`LSW_FAST_HALF_BIT] = abil_valid & PHY_STATUS.partner_fast_tx_half;
   end

   // Next state: request answer, drop counter and register port.
   // The word is sampled in the request cycle so the answer is one coherent snapshot.
   always_comb begin
      state_next = state_reg;
      state_next.resp_valid = req_ok;
      state_next.rdata = 32'h00000000;
      if (req_ok) begin
         state_next.resp_word = live_word;
         state_next.last_word = live_word;
      end
      // Saturating, so a storm of bad requests cannot wrap the count to zero.
      if (REQ && !req_ok && state_reg.drop_cnt != 16'hFFFF) begin
         state_next.drop_cnt = state_reg.drop_cnt + 16'h0001;
      end
      if (WR) begin
         unique case (ADDR)
            `LSW_OFF_CTRL: state_next.ctrl = WDATA[3:0];
            `LSW_OFF_DROP: state_next.drop_cnt = 16'h0000;
            default: state_next.ctrl = state_reg.ctrl;
         endcase
      end
      if (RD) begin
         unique case (ADDR)
            `LSW_OFF_CTRL: state_next.rdata = {28'h0000000, state_reg.ctrl};
            `LSW_OFF_LIVE: state_next.rdata = {18'h00000, live_word};
            `LSW_OFF_LAST: state_next.rdata = {18'h00000, state_reg.last_word};
            `LSW_OFF_DROP: state_next.rdata = {16'h0000, state_reg.drop_cnt};
            default: state_next.rdata = 32'h00000000;
         endcase
      end
   end

   // State register.
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= '0;
         state_reg.ctrl <= `LSW_CTRL_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register.
   assign RESP_VALID = state_reg.resp_valid;
   assign RESP_WORD = state_reg.resp_word;
   assign RDATA = state_reg.rdata;

   // Checks on the answered word.
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   a_link_flag_seen: assert property (
      req_ok |=> RESP_WORD[`LSW_LINK_BIT] ==
         ($past(PHY_STATUS.link_up) | $past(PHY_STATUS.low_power_idle)))
      else $error("Link flag does not follow link state.");

   a_good_req_answered: assert property (
      req_ok |=> RESP_VALID ##1 !RESP_VALID || $past(req_ok))
      else $error("Good request not answered in one cycle.");

   a_bad_req_dropped: assert property (
      REQ && (REQ_CHECKSUM_BAD || REQ_ID_BAD) |=> !RESP_VALID)
      else $error("Bad request was answered.");

   a_speed_forced_zero: assert property (
      req_ok && (PHY_STATUS.serdes || (an_flag && !PHY_STATUS.an_done))
      |=> RESP_VALID && RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == 4'h0)
      else $error("Speed field not zero while it must be.");

   a_ten_gig_code: assert property (
      req_ok && !an_flag && !PHY_STATUS.serdes && PHY_STATUS.link_up &&
      PHY_STATUS.media == lsw_pkg::MEDIA_10G
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == 4'h8)
      else $error("Ten gigabit link not coded as 0x8.");

   a_legacy_no_reserved: assert property (
      RESP_VALID && $past(state_reg.ctrl.legacy)
      |-> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] < 4'h9)
      else $error("Reserved speed code sent to a legacy reader.");

   a_an_flag_tracks: assert property (
      req_ok |=> RESP_WORD[`LSW_AN_EN_BIT] ==
         ($past(state_reg.ctrl.an_supported) && $past(state_reg.ctrl.an_enable)))
      else $error("Negotiation enabled bit wrong.");

   a_complete_needs_en: assert property (
      RESP_VALID && RESP_WORD[`LSW_AN_DONE_BIT] |-> RESP_WORD[`LSW_AN_EN_BIT])
      else $error("Complete flag set while negotiation is off.");

   a_pdet_needs_done: assert property (
      RESP_VALID && RESP_WORD[`LSW_PDET_BIT]
      |-> RESP_WORD[`LSW_AN_DONE_BIT] && $past(PHY_STATUS.parallel_det))
      else $error("Parallel detection flag without its cause.");

   a_abilities_gated: assert property (
      RESP_VALID && (|RESP_WORD[`LSW_FAST_HALF_BIT:`LSW_GIG_FULL_BIT])
      |-> RESP_WORD[`LSW_AN_DONE_BIT] && !$past(PHY_STATUS.serdes))
      else $error("Partner ability reported while invalid.");

   a_reserved_bit_zero: assert property (
      RESP_VALID |-> !RESP_WORD[`LSW_RSVD_BIT])
      else $error("Reserved bit 8 set.");

   // Forced-setting condition for the code checks below: no negotiation, no SerDes
   // and a live link, so the medium and the legacy and ext_ok control bits decide the speed field.
   logic forced_up;
   assign forced_up = !an_flag && !PHY_STATUS.serdes && PHY_STATUS.link_up;

   // Answer pulse and word: nothing moves without a good request.
   a_no_req_no_answer: assert property (
      !req_ok |=> !RESP_VALID)
      else $error("Answer sent without a good request.");

   a_word_holds: assert property (
      !req_ok |=> $stable(RESP_WORD))
      else $error("Answered word changed without a good request.");

   // Speed field forced to zero: no common ability, or a forced link that is down.
   a_no_common_zero: assert property (
      req_ok && an_flag && !PHY_STATUS.highest_common_ability
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_NONE)
      else $error("Speed field not zero without a common ability.");

   a_forced_down_zero: assert property (
      req_ok && !an_flag && !PHY_STATUS.link_up
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_NONE)
      else $error("Speed field not zero for a forced link that is down.");

   // One check per copper code, for 0xA, 0xD and 0xF and for two legacy fallbacks, taken on forced links where the medium decides.
   a_ten_half_code: assert property (
      req_ok && forced_up && PHY_STATUS.media == lsw_pkg::MEDIA_10H
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_10H)
      else $error("Ten megabit half duplex code wrong.");

   a_ten_full_code: assert property (
      req_ok && forced_up && PHY_STATUS.media == lsw_pkg::MEDIA_10F
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_10F)
      else $error("Ten megabit full duplex code wrong.");

   a_fast_half_code: assert property (
      req_ok && forced_up && PHY_STATUS.media == lsw_pkg::MEDIA_100H
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_100H)
      else $error("Hundred megabit half duplex code wrong.");

   a_fast_full_code: assert property (
      req_ok && forced_up && PHY_STATUS.media == lsw_pkg::MEDIA_100F
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_100F)
      else $error("Hundred megabit full duplex code wrong.");

   a_gig_half_code: assert property (
      req_ok && forced_up && PHY_STATUS.media == lsw_pkg::MEDIA_1000H
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_1000H)
      else $error("Gigabit half duplex code wrong.");

   a_gig_full_code: assert property (
      req_ok && forced_up && PHY_STATUS.media == lsw_pkg::MEDIA_1000F
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_1000F)
      else $error("Gigabit full duplex code wrong.");

   a_quarter_code: assert property (
      req_ok && forced_up && !state_reg.ctrl.legacy &&
      PHY_STATUS.media == lsw_pkg::MEDIA_25G
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_25G)
      else $error("Optional 25 gigabit code wrong.");

   a_hundred_gig_code: assert property (
      req_ok && forced_up && !state_reg.ctrl.legacy &&
      PHY_STATUS.media == lsw_pkg::MEDIA_100G
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_100G)
      else $error("Optional 100 gigabit code wrong.");

   a_ext_code: assert property (
      req_ok && forced_up && state_reg.ctrl.ext_ok && !state_reg.ctrl.legacy &&
      PHY_STATUS.media == lsw_pkg::MEDIA_EXT
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_EXT)
      else $error("Extended speed code not reported.");

   a_legacy_slow_near: assert property (
      req_ok && forced_up && state_reg.ctrl.legacy &&
      PHY_STATUS.media == lsw_pkg::MEDIA_2G5
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_1000F)
      else $error("Legacy reader not given the nearest code for 2.5 gigabit.");

   a_legacy_fast_near: assert property (
      req_ok && forced_up && state_reg.ctrl.legacy &&
      PHY_STATUS.media == lsw_pkg::MEDIA_40G
      |=> RESP_WORD[`LSW_SPEED_HI:`LSW_SPEED_LO] == `LSW_SPD_10G)
      else $error("Legacy reader not given the nearest code for 40 gigabit.");

   // Flag and ability bits against their causes in the request cycle.
   a_complete_follows: assert property (
      req_ok |=> RESP_WORD[`LSW_AN_DONE_BIT] ==
         ($past(an_flag) && $past(PHY_STATUS.an_done)))
      else $error("Negotiation complete bit wrong.");

   a_pdet_follows: assert property (
      req_ok |=> RESP_WORD[`LSW_PDET_BIT] ==
         ($past(an_flag) && $past(PHY_STATUS.an_done) && $past(PHY_STATUS.parallel_det)))
      else $error("Parallel detection bit wrong.");

   a_serdes_no_abil: assert property (
      req_ok && PHY_STATUS.serdes
      |=> RESP_WORD[`LSW_FAST_HALF_BIT:`LSW_GIG_FULL_BIT] == 5'h00)
      else $error("Partner ability reported on a SerDes link.");

   a_no_neg_no_abil: assert property (
      req_ok && !an_flag
      |=> RESP_WORD[`LSW_FAST_HALF_BIT:`LSW_GIG_FULL_BIT] == 5'h00)
      else $error("Partner ability reported without negotiation.");

   // Register port: control write, drop counter and idle read data.
   a_ctrl_write: assert property (
      WR && ADDR == `LSW_OFF_CTRL |=> state_reg.ctrl == $past(WDATA[3:0]))
      else $error("Control write did not land.");

   a_drop_counts: assert property (
      REQ && !req_ok && !WR && state_reg.drop_cnt != 16'hFFFF
      |=> state_reg.drop_cnt == $past(state_reg.drop_cnt) + 16'h0001)
      else $error("Refused request not counted.");

   a_drop_clear: assert property (
      WR && ADDR == `LSW_OFF_DROP |=> state_reg.drop_cnt == 16'h0000)
      else $error("Drop counter not cleared by a write.");

   a_rdata_idle: assert property (
      !RD |=> RDATA == 32'h00000000)
      else $error("Read data not zero outside a read answer.");

endmodule

// file: hdl/lsw_params.svh
// Constants for the link status word encoder: bit positions, codes, offsets, resets.
// Assumes inclusion by bare name from the package and the encoder module.
`ifndef LSW_PARAMS_SVH
`define LSW_PARAMS_SVH

// Field positions inside the link status word.
`define LSW_WORD_W 14
`define LSW_LINK_BIT 0
`define LSW_SPEED_LO 1
`define LSW_SPEED_HI 4
`define LSW_AN_EN_BIT 5
`define LSW_AN_DONE_BIT 6
`define LSW_PDET_BIT 7
`define LSW_RSVD_BIT 8
`define LSW_GIG_FULL_BIT 9
`define LSW_GIG_HALF_BIT 10
`define LSW_FAST_T4_BIT 11
`define LSW_FAST_FULL_BIT 12
`define LSW_FAST_HALF_BIT 13

// Speed and duplex codes.
`define LSW_SPD_NONE 4'h0
`define LSW_SPD_10H 4'h1
`define LSW_SPD_10F 4'h2
`define LSW_SPD_100H 4'h3
`define LSW_SPD_100F 4'h5
`define LSW_SPD_1000H 4'h6
`define LSW_SPD_1000F 4'h7
`define LSW_SPD_10G 4'h8
`define LSW_SPD_20G 4'h9
`define LSW_SPD_25G 4'hA
`define LSW_SPD_40G 4'hB
`define LSW_SPD_50G 4'hC
`define LSW_SPD_100G 4'hD
`define LSW_SPD_2G5 4'hE
`define LSW_SPD_EXT 4'hF

// Register offsets (byte addresses) and control field positions.
`define LSW_ADDR_W 8
`define LSW_OFF_CTRL 8'h00
`define LSW_OFF_LIVE 8'h04
`define LSW_OFF_LAST 8'h08
`define LSW_OFF_DROP 8'h0C
`define LSW_CTRL_AN_SUP 0
`define LSW_CTRL_AN_EN 1
`define LSW_CTRL_EXT_OK 2
`define LSW_CTRL_LEGACY 3
`define LSW_CTRL_RESET 4'h3

`endif

// file: hdl/lsw_pkg.sv
// Types shared by the link status word encoder and its bench.
// Assumes lsw_params.svh is on the include path.
`include "lsw_params.svh"

package lsw_pkg;

   // Resolved medium and speed as seen by the PHY management logic.
   typedef enum logic [3:0] {
      MEDIA_NONE = 4'h0,
      MEDIA_10H = 4'h1,
      MEDIA_10F = 4'h2,
      MEDIA_100H = 4'h3,
      MEDIA_100F = 4'h4,
      MEDIA_1000H = 4'h5,
      MEDIA_1000F = 4'h6,
      MEDIA_10G = 4'h7,
      MEDIA_20G = 4'h8,
      MEDIA_25G = 4'h9,
      MEDIA_40G = 4'hA,
      MEDIA_50G = 4'hB,
      MEDIA_100G = 4'hC,
      MEDIA_2G5 = 4'hD,
      MEDIA_EXT = 4'hE
   } media_type;

   // Live status gathered from the PHY.
   typedef struct packed {
      logic link_up;
      logic low_power_idle;
      logic an_done;
      logic parallel_det;
      logic serdes;
      logic highest_common_ability;
      media_type media;
      logic partner_gig_copper_full;
      logic partner_gig_copper_half;
      logic partner_fast_four_pair;
      logic partner_fast_tx_full;
      logic partner_fast_tx_half;
   } phy_status_type;

   // Control bits written by software.
   typedef struct packed {
      logic legacy;
      logic ext_ok;
      logic an_enable;
      logic an_supported;
   } ctrl_type;

   // All state of the encoder.
   typedef struct packed {
      ctrl_type ctrl;
      logic resp_valid;
      logic [`LSW_WORD_W-1:0] resp_word;
      logic [`LSW_WORD_W-1:0] last_word;
      logic [15:0] drop_cnt;
      logic [31:0] rdata;
   } state_type;

endpackage

// file: tb/link_status_word_encoder_test.sv
// Self-checking bench for the link status word encoder.
// Assumes lsw_params.svh on the include path and the package compiled first.
`timescale 1ns/1ns
`include "lsw_params.svh"

module link_status_word_encoder_test;
   logic CLOCK, RESETN, REQ, REQ_CHECKSUM_BAD, REQ_ID_BAD, WR, RD, RESP_VALID;
   lsw_pkg::phy_status_type PHY_STATUS;
   logic [7:0] ADDR;
   logic [31:0] WDATA, RDATA;
   logic [13:0] RESP_WORD;
   int n_mismatch, checks_done;
   logic [31:0] resp_q[$];
   logic [31:0] rd_q[$];
   logic rd_d = 1'b0;
   logic [3:0] ctrl_v;
   logic [31:0] last_v;
   localparam logic [3:0] code_map [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};

   link_status_word_encoder i_link_status_word_encoder (.CLOCK(CLOCK), .RESETN(RESETN),
      .PHY_STATUS(PHY_STATUS), .REQ(REQ), .REQ_CHECKSUM_BAD(REQ_CHECKSUM_BAD),
      .REQ_ID_BAD(REQ_ID_BAD), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RESP_VALID(RESP_VALID), .RESP_WORD(RESP_WORD), .RDATA(RDATA));

   lsw_mgmt_model i_lsw_mgmt_model (.clock(CLOCK), .req(REQ),
      .checksum_bad(REQ_CHECKSUM_BAD), .id_bad(REQ_ID_BAD));

   // Expected word, worked out independently from the field definitions.
   function automatic logic [31:0] enc(lsw_pkg::phy_status_type p, logic [3:0] c);
      logic an, dn;
      logic [3:0] m, s;
      an = c[0] & c[1];
      dn = an & p.an_done;
      m = p.media;
      s = code_map[m];
      if (c[3] && m >= 4'h8 && m <= 4'hC) s = 4'h8;
      if (c[3] && m == 4'hD) s = 4'h7;
      if (m == 4'hE && (c[3] || !c[2])) s = 4'h0;
      if (p.serdes | (an & (!p.an_done | !p.highest_common_ability)) | (!an & !p.link_up))
         s = 4'h0;
      return {18'h0, {p.partner_fast_tx_half, p.partner_fast_tx_full, p.partner_fast_four_pair,
         p.partner_gig_copper_half, p.partner_gig_copper_full} & {5{!p.serdes & dn}},
         1'b0, dn & p.parallel_det, dn, an, s, p.link_up | p.low_power_idle};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bus tasks leave the strobe up so that back-to-back cycles need no gap.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      RD <= 1'b0;
      @(posedge CLOCK);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ADDR <= a;
      WR <= 1'b0;
      RD <= 1'b1;
      rd_q.push_back(e);
      @(posedge CLOCK);
   endtask

   task automatic bus_idle();
      WR <= 1'b0;
      RD <= 1'b0;
      @(posedge CLOCK);
   endtask

   // Random status travels with each request; only good ones expect an answer.
   task automatic request(input logic ck, input logic id);
      logic [14:0] r;
      lsw_pkg::phy_status_type p;
      r = 15'($urandom);
      p = r;
      p.media = lsw_pkg::media_type'(4'($urandom_range(14)));
      PHY_STATUS <= p;
      if (!ck && !id) begin
         last_v = enc(p, ctrl_v);
         resp_q.push_back(last_v);
      end
      i_lsw_mgmt_model.issue(ck, id);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Clock at 100 MHz.
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end

   // Answers and read data are matched against the oldest note in order.
   always @(posedge CLOCK) begin
      if (rd_d) chk(RDATA, rd_q.pop_front());
      rd_d <= RD;
      if (RESP_VALID === 1'b1) begin
         if (resp_q.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(RESP_WORD), resp_q.pop_front());
      end
   end

   // Main sequence: reset, every control setting with random status, refusals.
   initial begin
      RESETN = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 8'h00;
      WDATA = 32'h0;
      PHY_STATUS = '0;
      n_mismatch = 0;
      checks_done = 0;
      ctrl_v = `LSW_CTRL_RESET;
      last_v = 32'h0;
      void'($urandom(83064));
      repeat (4) @(posedge CLOCK);
      RESETN <= 1'b1;
      rd(`LSW_OFF_CTRL, 32'h3);
      rd(8'h10, 32'h0);
      rd(`LSW_OFF_DROP, 32'h0);
      rd(`LSW_OFF_LAST, 32'h0);
      for (int c = 0; c < 16; c++) begin
         wr(`LSW_OFF_CTRL, 32'(c));
         ctrl_v = 4'(c);
         rd(`LSW_OFF_CTRL, 32'(c));
         bus_idle();
         repeat (64) request(1'b0, 1'b0);
         i_lsw_mgmt_model.drop_req();
      end
      request(1'b1, 1'b0);
      request(1'b0, 1'b1);
      request(1'b1, 1'b1);
      request(1'b0, 1'b0);
      i_lsw_mgmt_model.drop_req();
      rd(`LSW_OFF_DROP, 32'h3);
      wr(`LSW_OFF_DROP, 32'h0);
      rd(`LSW_OFF_DROP, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd(`LSW_OFF_CTRL, 32'(ctrl_v));
      rd(`LSW_OFF_LAST, last_v);
      rd(`LSW_OFF_LIVE, enc(PHY_STATUS, ctrl_v));
      bus_idle();
      chk(32'(RESP_WORD), last_v);
      // Mid-run reset after one more refused request: everything returns to rest.
      request(1'b1, 1'b1);
      i_lsw_mgmt_model.drop_req();
      RESETN <= 1'b0;
      repeat (2) @(posedge CLOCK);
      chk(32'(RESP_WORD), 32'h0);
      chk(32'(RESP_VALID), 32'h0);
      RESETN <= 1'b1;
      ctrl_v = `LSW_CTRL_RESET;
      rd(`LSW_OFF_CTRL, 32'(ctrl_v));
      rd(`LSW_OFF_DROP, 32'h0);
      rd(`LSW_OFF_LAST, 32'h0);
      bus_idle();
      for (int i = 0; i < 20 && (resp_q.size() + rd_q.size()) > 0; i++) @(posedge CLOCK);
      if ((resp_q.size() + rd_q.size()) > 0) n_mismatch++;
      give_verdict();
   end

   // A hang is cut short well inside the cycle budget.
   initial begin
      #500000;
      n_mismatch++;
      give_verdict();
   end

endmodule

// file: tb/lsw_mgmt_model.sv
// Management controller model: issues get-link-status requests to the encoder.
// Assumes its tasks are called right after a rising edge of the clock.
`timescale 1ns/1ns

module lsw_mgmt_model (
   input wire logic clock,
   output logic req,
   output logic checksum_bad,
   output logic id_bad
);

   // Idle at time zero.
   initial begin
      req = 1'b0;
      checksum_bad = 1'b0;
      id_bad = 1'b0;
   end

   // One request per edge; back-to-back calls keep the request high.
   task automatic issue(input logic ck, input logic id);
      req <= 1'b1;
      checksum_bad <= ck;
      id_bad <= id;
      @(posedge clock);
   endtask

   // Idle qualifiers flip so that a stale value is never mistaken for a live one.
   task automatic drop_req();
      req <= 1'b0;
      checksum_bad <= ~checksum_bad;
      id_bad <= ~id_bad;
      @(posedge clock);
   endtask

endmodule
